// >>> hw/ltc_pkg.sv
/*
 * Constants for the panel timing control block: register offsets, field positions,
 * reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none
package ltc_pkg;
   // Register byte offsets
   localparam logic [7:0]  TIMING_OFFSET   = 8'h00;  // Panel timing control two
   localparam logic [7:0]  CONTROL_OFFSET  = 8'h04;  // Enable and display mode
   localparam logic [7:0]  STATUS_OFFSET   = 8'h08;  // Sticky bias count status
   // Timing register field positions
   localparam int          DIV_LSB         = 0;      // Pixel clock divider, 8 bits
   localparam int          PER_LSB         = 8;      // Bias toggle period, 8 bits
   localparam int          TPI_LSB         = 16;     // Transitions per irq, 4 bits
   localparam int          FS_INV_BIT      = 20;     // Frame sync invert
   localparam int          LS_INV_BIT      = 21;     // Line sync invert
   localparam int          PC_INV_BIT      = 22;     // Pixel clock invert
   localparam int          OE_INV_BIT      = 23;     // Output enable invert
   localparam int          SEL_BIT         = 24;     // Sync edge select
   localparam int          ON_BIT          = 25;     // Sync edge control on
   localparam int          FIELD_W         = 26;     // Writable width
   localparam logic [31:0] RSVD_ONES       = 32'hfc000000; // Reserved bits read as ones
   // Control and status field positions
   localparam int          ENABLE_BIT      = 0;      // Controller enable
   localparam int          ACTIVE_BIT      = 1;      // Active display select
   localparam int          COUNT_BIT       = 0;      // Bias count status
   // Reset values
   localparam logic [25:0] TIMING_RESET    = 26'h0000000;
   localparam logic [1:0]  CONTROL_RESET   = 2'h0;
   // Divider floor
   localparam logic [7:0]  DIV_MIN         = 8'h02;
   // Bus responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage
`default_nettype wire

// >>> hw/ltc_pixel_divider.sv
/*
 * Pixel clock divider: divides the controller clock by the divider field.
 * Assumes the divider value only changes while run is low.
 */
`default_nettype none
module ltc_pixel_divider #(
   parameter int W = 8                     // Divider field width
) (
   input  wire logic         aclk,         // Controller clock
   input  wire logic         aresetn,      // Synchronous reset, active low
   input  wire logic         run,          // Divider runs while high
   input  wire logic [W-1:0] divider,      // Division ratio
   output logic              pclk_ff,      // Pixel clock level
   output logic              rise,         // Pixel clock rises next edge
   output logic              fall          // Pixel clock falls next edge
);
   logic [W-1:0] cnt_ff;                   // Phase counter
   logic [W-1:0] ratio;                    // Ratio clamped to the floor
   logic [W-1:0] half;                     // Phase of the falling edge

   // Values below the floor act as the floor
   assign ratio = (divider < ltc_pkg::DIV_MIN) ? W'(ltc_pkg::DIV_MIN) : divider;
   assign half  = ratio >> 1;
   // Edge strobes lead the pixel clock by one cycle
   assign rise  = run && (cnt_ff == '0);
   assign fall  = run && (cnt_ff == half);

   // Phase counter wraps after ratio cycles
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         cnt_ff <= '0;
      end else if (cnt_ff == ratio - 1'b1) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // Pixel clock level follows the strobes
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         pclk_ff <= 1'b0;
      end else if (rise) begin
         pclk_ff <= 1'b1;
      end else if (fall) begin
         pclk_ff <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> hw/ltc_timing_two.sv
/*
 * Panel timing control: the second timing register, its AXI4-Lite slave, sync
 * polarity and edge alignment, ac-bias generation and transition counting.
 * Assumes the horizontal and vertical timing logic on the same clock supplies
 * the raw sync requests, the first-line flag and the pixel data valid level.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
// Overview of operation
// - Reserved top bits ignore writes, read ones
// - Default: syncs on edge opposite data
// - Edge control on: select picks fall/rise
// - Explicit edge control only in active mode
// - Active mode: output enable polarity bit
// - Pixel clock invert picks data launch edge
// - Line sync polarity from invert bit
// - Line sync pulses between lines
// - Frame sync polarity from invert bit
// - Active: frame sync between frames
// - Passive: frame sync held first line
// - Count bias transitions, then set status
// - Counter frozen while status set
// - Zero count field disables status setting
// - Bias toggles every period plus one line clocks
// - Pixel clock is controller clock divided
// - Active: bias output acts as enable
// - Status sticky, write one clears
module ltc_timing_two (
   input  wire logic        aclk,             // Controller clock
   input  wire logic        aresetn,          // Synchronous reset, active low
   input  wire logic [7:0]  awaddr,           // Write address
   input  wire logic [2:0]  awprot,           // Write protection, unused
   input  wire logic        awvalid,          // Write address valid
   output logic             awready,          // Write address ready
   input  wire logic [31:0] wdata,            // Write data
   input  wire logic [3:0]  wstrb,            // Write byte strobes
   input  wire logic        wvalid,           // Write data valid
   output logic             wready,           // Write data ready
   output logic [1:0]       bresp,            // Write response
   output logic             bvalid,           // Write response valid
   input  wire logic        bready,           // Write response ready
   input  wire logic [7:0]  araddr,           // Read address
   input  wire logic [2:0]  arprot,           // Read protection, unused
   input  wire logic        arvalid,          // Read address valid
   output logic             arready,          // Read address ready
   output logic [31:0]      rdata,            // Read data
   output logic [1:0]       rresp,            // Read response
   output logic             rvalid,           // Read data valid
   input  wire logic        rready,           // Read data ready
   input  wire logic        line_sync_req,    // Raw line sync from line timing
   input  wire logic        frame_sync_req,   // Raw frame sync from frame timing
   input  wire logic        first_line,       // High during first line of frame
   input  wire logic        pixel_data_valid, // Pixel data driven this pixel
   output logic             pixel_clock_out,  // Pixel clock pin
   output logic             data_launch,      // Data launched with this pclk edge
   output logic             line_sync_out,    // Line sync pin
   output logic             frame_sync_out,   // Frame sync pin
   output logic             bias_out,         // Ac-bias pin
   output logic             bias_count_status // Sticky count status flag
);
   logic [25:0] timing_ff;        // Writable timing fields
   logic [1:0]  control_ff;       // Enable and mode
   logic        status_ff;        // Sticky bias count status
   logic        aw_held_ff;       // Write address captured
   logic [7:0]  awaddr_ff;        // Captured write address
   logic        w_held_ff;        // Write data captured
   logic [31:0] wdata_ff;         // Captured write data
   logic [3:0]  wstrb_ff;         // Captured strobes
   logic        bvalid_ff;        // Write response pending
   logic [1:0]  bresp_ff;         // Write response code
   logic        rvalid_ff;        // Read response pending
   logic [31:0] rdata_ff;         // Read data
   logic [1:0]  rresp_ff;         // Read response code
   logic        line_sync_ff;     // Line sync pin register
   logic        frame_sync_ff;    // Frame sync pin register
   logic        bias_ff;          // Bias pin register
   logic        launch_ff;        // Data launch strobe register
   logic        line_req_d_ff;    // Delayed line request for edge detect
   logic [7:0]  period_cnt_ff;    // Line clock down counter
   logic [3:0]  trans_cnt_ff;     // Bias transition down counter
   logic        do_write;         // Both write halves held
   logic [31:0] wr_value;         // Merged write value
   logic        enable;           // Controller enable
   logic        active;           // Active display mode
   logic        rise;             // Pixel clock rises next edge
   logic        fall;             // Pixel clock falls next edge
   logic        data_edge;        // Data launch edge strobe
   logic        opp_edge;         // Edge opposite the data edge
   logic        sync_edge;        // Edge on which syncs change
   logic        frame_level;      // Frame sync before polarity
   logic        line_tick;        // One line clock
   logic        toggle_now;       // Bias period elapsed
   logic        nxt_bias;         // Next bias pin value
   logic        transition;       // Bias pin changes this edge
   logic        count_hit;        // Transition count reached
   logic        status_clear;     // Software clears status
   logic [3:0]  trans_n;          // Transitions per status
   logic        on_b;             // Sync edge control on
   logic        sel_b;            // Sync edge select
   logic        oe_inv;           // Output enable invert
   logic        pc_inv;           // Pixel clock invert
   logic        ls_inv;           // Line sync invert
   logic        fs_inv;           // Frame sync invert

   // Address decode shared by the read and write paths
   function automatic logic reg_hit(input logic [7:0] addr);
      reg_hit = (addr == ltc_pkg::TIMING_OFFSET) || (addr == ltc_pkg::CONTROL_OFFSET)
             || (addr == ltc_pkg::STATUS_OFFSET);
   endfunction

   // Merge write data into an old word under the byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      merge = res;
   endfunction

   // Field views
   assign enable = control_ff[ltc_pkg::ENABLE_BIT];
   assign active = control_ff[ltc_pkg::ACTIVE_BIT];
   assign trans_n = timing_ff[ltc_pkg::TPI_LSB +: 4];
   assign on_b    = timing_ff[ltc_pkg::ON_BIT];
   assign sel_b   = timing_ff[ltc_pkg::SEL_BIT];
   assign oe_inv  = timing_ff[ltc_pkg::OE_INV_BIT];
   assign pc_inv  = timing_ff[ltc_pkg::PC_INV_BIT];
   assign ls_inv  = timing_ff[ltc_pkg::LS_INV_BIT];
   assign fs_inv  = timing_ff[ltc_pkg::FS_INV_BIT];

   // Bus handshakes; one write and one read at a time
   assign awready  = !aw_held_ff && !bvalid_ff;
   assign wready   = !w_held_ff && !bvalid_ff;
   assign arready  = !rvalid_ff;
   assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_value = merge(ltc_pkg::RSVD_ONES | {6'h00, timing_ff}, wdata_ff, wstrb_ff);
   assign bvalid   = bvalid_ff;
   assign bresp    = bresp_ff;
   assign rvalid   = rvalid_ff;
   assign rdata    = rdata_ff;
   assign rresp    = rresp_ff;

   // Write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         awaddr_ff  <= 8'h00;
      end else if (awvalid && awready) begin
         aw_held_ff <= 1'b1;
         awaddr_ff  <= awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         wdata_ff  <= 32'h00000000;
         wstrb_ff  <= 4'h0;
      end else if (wvalid && wready) begin
         w_held_ff <= 1'b1;
         wdata_ff  <= wdata;
         wstrb_ff  <= wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   // Write response; unmapped addresses answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= ltc_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= reg_hit(awaddr_ff) ? ltc_pkg::RESP_OKAY : ltc_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Timing and control registers; reserved bits are dropped on write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timing_ff  <= ltc_pkg::TIMING_RESET;
         control_ff <= ltc_pkg::CONTROL_RESET;
      end else if (do_write && awaddr_ff == ltc_pkg::TIMING_OFFSET) begin
         timing_ff  <= wr_value[ltc_pkg::FIELD_W-1:0];
      end else if (do_write && awaddr_ff == ltc_pkg::CONTROL_OFFSET && wstrb_ff[0]) begin
         control_ff <= wdata_ff[1:0];
      end
   end

   // Read path; reserved timing bits read as ones
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= ltc_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= reg_hit(araddr) ? ltc_pkg::RESP_OKAY : ltc_pkg::RESP_SLVERR;
         case (araddr)
            ltc_pkg::TIMING_OFFSET:  rdata_ff <= ltc_pkg::RSVD_ONES | {6'h00, timing_ff};
            ltc_pkg::CONTROL_OFFSET: rdata_ff <= {30'h00000000, control_ff};
            ltc_pkg::STATUS_OFFSET:  rdata_ff <= {31'h00000000, status_ff};
            default:                 rdata_ff <= 32'h00000000;
         endcase
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Pixel clock generation
   ltc_pixel_divider #(
      .W       (8)
   ) ltc_pixel_divider_i (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (enable),
      .divider (timing_ff[ltc_pkg::DIV_LSB +: 8]),
      .pclk_ff (pixel_clock_out),
      .rise    (rise),
      .fall    (fall)
   );

   // Edge selection for data and syncs
   assign data_edge = pc_inv ? fall : rise;
   assign opp_edge  = pc_inv ? rise : fall;
   assign sync_edge = (on_b && active) ? (sel_b ? rise : fall)
                                       : opp_edge;
   // Passive mode frame clock covers the first line
   assign frame_level = active ? frame_sync_req : first_line;

   // Data launch strobe, aligned with the pixel clock edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         launch_ff <= 1'b0;
      end else begin
         launch_ff <= enable && data_edge;
      end
   end
   assign data_launch = launch_ff;

   // Line sync pin: pulse between lines, polarity applied
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_sync_ff <= 1'b0;
      end else if (!enable) begin
         line_sync_ff <= ls_inv;
      end else if (sync_edge) begin
         line_sync_ff <= line_sync_req ^ ls_inv;
      end
   end
   assign line_sync_out = line_sync_ff;

   // Frame sync pin: polarity applied
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_sync_ff <= 1'b0;
      end else if (!enable) begin
         frame_sync_ff <= fs_inv;
      end else if (sync_edge) begin
         frame_sync_ff <= frame_level ^ fs_inv;
      end
   end
   assign frame_sync_out = frame_sync_ff;

   // Line clock edge detect for the bias period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_req_d_ff <= 1'b0;
      end else begin
         line_req_d_ff <= line_sync_req;
      end
   end
   assign line_tick  = enable && line_sync_req && !line_req_d_ff;
   assign toggle_now = line_tick && (period_cnt_ff == 8'h00);

   // Bias period down counter, reloaded after each toggle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_cnt_ff <= 8'h00;
      end else if (!enable || toggle_now) begin
         period_cnt_ff <= timing_ff[ltc_pkg::PER_LSB +: 8];
      end else if (line_tick) begin
         period_cnt_ff <= period_cnt_ff - 8'h01;
      end
   end

   // Bias pin: enable in active mode, periodic toggle in passive mode
   always_comb begin
      nxt_bias = bias_ff;
      if (!enable) begin
         nxt_bias = active && oe_inv;
      end else if (active) begin
         if (data_edge) begin
            nxt_bias = pixel_data_valid ^ oe_inv;
         end
      end else if (toggle_now) begin
         nxt_bias = !bias_ff;
      end
   end

   // Bias pin register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bias_ff <= 1'b0;
      end else begin
         bias_ff <= nxt_bias;
      end
   end
   assign bias_out = bias_ff;

   // Transition counting toward the status flag
   assign transition = enable && (nxt_bias != bias_ff);
   assign count_hit  = transition && (trans_n != 4'h0) && !status_ff
                    && (trans_cnt_ff == 4'h1);
   assign status_clear = do_write && awaddr_ff == ltc_pkg::STATUS_OFFSET
                      && wstrb_ff[0] && wdata_ff[ltc_pkg::COUNT_BIT];

   // Transition down counter; held at the reload value while status is set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trans_cnt_ff <= 4'h0;
      end else if (!enable || status_ff || count_hit) begin
         trans_cnt_ff <= trans_n;
      end else if (transition && trans_n != 4'h0) begin
         trans_cnt_ff <= trans_cnt_ff - 4'h1;
      end
   end

   // Sticky status; a new hit wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= 1'b0;
      end else if (count_hit) begin
         status_ff <= 1'b1;
      end else if (status_clear) begin
         status_ff <= 1'b0;
      end
   end
   assign bias_count_status = status_ff;

   // Checks on the block's outputs and on its transition counter
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   rsvd_read_ones_a: assert property (
      (arvalid && arready && araddr == ltc_pkg::TIMING_OFFSET) |=> rdata[31:26] == 6'h3f)
      else $error("reserved bits not read as ones");
   line_polarity_a: assert property (
      (enable && sync_edge) |=> line_sync_out == ($past(line_sync_req) ^ $past(ls_inv)))
      else $error("line sync polarity wrong");
   default_edge_a: assert property (
      (enable && $past(enable) && !$past(on_b && active) && $changed(line_sync_out))
      |-> $past(opp_edge))
      else $error("sync not on edge opposite data");
   select_edge_a: assert property (
      (enable && $past(enable) && $past(on_b && active) && $changed(line_sync_out))
      |-> $past(sel_b ? rise : fall))
      else $error("sync not on selected edge");
   frame_passive_a: assert property (
      (enable && !active && sync_edge) |=> frame_sync_out == ($past(first_line) ^ $past(fs_inv)))
      else $error("passive frame clock wrong");
   oe_polarity_a: assert property (
      (enable && active && data_edge) |=> bias_out == ($past(pixel_data_valid) ^ $past(oe_inv)))
      else $error("output enable polarity wrong");
   launch_edge_a: assert property (
      data_launch |-> (pc_inv ? $fell(pixel_clock_out) : $rose(pixel_clock_out)))
      else $error("data launched on wrong edge");
   count_freeze_a: assert property (
      status_ff |=> trans_cnt_ff == $past(trans_n))
      else $error("transition counter moved while frozen");
   zero_disable_a: assert property (
      (trans_n == 4'h0 && !status_ff) |=> !status_ff)
      else $error("status set with counting disabled");
   clear_one_a: assert property (
      (status_clear && !count_hit) |=> !status_ff)
      else $error("status not cleared by one");
   bias_toggle_a: assert property (
      (enable && !active && toggle_now) |=> $changed(bias_out))
      else $error("bias did not toggle after period");

   status_set_c: cover property (count_hit);
   write_done_c: cover property (bvalid && bready);
   read_done_c:  cover property (rvalid && rready);
   active_oe_c:  cover property (enable && active && $rose(bias_out));
endmodule
`default_nettype wire

// >>> dv/ltc_panel_model.sv
/* Panel model: measures the pixel clock period in controller clocks.
   Assumes it shares the controller clock. */
`default_nettype none
module ltc_panel_model (
   input  wire logic aclk,
   input  wire logic pclk,
   output int        period
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt_ff = 0;  // Cycles since last rise
   logic last_ff = 0; // Previous pixel clock level
   // Latch the rise-to-rise spacing
   always @(posedge aclk) begin
      cnt_ff <= cnt_ff + 1;
      last_ff <= pclk;
      if (pclk && !last_ff) begin
         period <= cnt_ff + 1;
         cnt_ff <= 0;
      end
   end
endmodule
`default_nettype wire

// >>> dv/lcd_timing_control_two_test.sv
/* Testbench for the timing block: AXI4-Lite tasks, one task per scenario.
   Assumes the panel model and the design files are compiled first. */
`default_nettype none
module lcd_timing_control_two_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd_v;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, lsr = 0, fl = 0, pdv = 0, fsr = 0;
   logic pclk, lso, fso, bias, stat, dl;
   int period, err_total = 0, n_tests = 0;
   ltc_timing_two ltc_timing_two_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_sync_req(lsr),
      .frame_sync_req(fsr), .first_line(fl), .pixel_data_valid(pdv),
      .pixel_clock_out(pclk), .data_launch(dl), .line_sync_out(lso), .frame_sync_out(fso),
      .bias_out(bias), .bias_count_status(stat));
   ltc_panel_model ltc_panel_model_i (.aclk(aclk), .pclk(pclk), .period(period));
   // Clock at 20 ns
   initial begin
      forever #10 aclk = ~aclk;
   end
   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write: both halves offered together, each released when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      bit pa, pw;
      pa = 1;
      pw = 1;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (pa || pw) begin
         @(posedge aclk);
         if (pa && awready) begin pa = 0; awvalid <= 0; end
         if (pw && wready) begin pw = 0; wvalid <= 0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd_v = rdata;
      rready <= 0;
   endtask
   // Line clock pulses
   task lines(input int n);
      repeat (n) begin
         lsr <= 1; repeat (3) @(posedge aclk);
         lsr <= 0; repeat (5) @(posedge aclk);
      end
   endtask
   // Reserved bits, writable bits, unmapped read, idle polarity
   task t_regs;
      rd(8'h00); chk(rd_v, 32'hfc000000);
      wr(8'h00, 32'hffffffff); rd(8'h00); chk(rd_v, 32'hffffffff);
      chk({lso, fso}, 2'h3);
      rd(8'h10); chk(rresp, ltc_pkg::RESP_SLVERR);
      wr(8'h00, 32'h03c00000); rd(8'h00); chk(rd_v, 32'hffc00000);
      chk({lso, fso}, 2'h0);
   endtask
   // Divider 4, passive, period 1, two transitions per status
   task t_run;
      logic b0;
      wr(8'h00, 32'h00020104); wr(8'h04, 32'h1);
      repeat (20) @(posedge aclk);
      chk(period, 4);
      fl <= 1; repeat (12) @(posedge aclk);
      chk(fso, 1'b1);
      fl <= 0; repeat (12) @(posedge aclk);
      chk(fso, 1'b0);
      b0 = bias;
      lines(1); chk(bias, b0);
      lines(1); chk(bias, !b0); chk(stat, 1'b0);
      lines(2); chk(stat, 1'b1);
      lines(4); wr(8'h08, 32'h0); chk(stat, 1'b1);
      wr(8'h08, 32'h1); chk(stat, 1'b0);
      lines(2); chk(stat, 1'b0);
      lines(2); chk(stat, 1'b1);
   endtask
   // Active mode: output enable, frame sync, launch edge, selected sync edge
   task t_active;
      wr(8'h04, 32'h0); wr(8'h00, 32'h03900004); wr(8'h04, 32'h3);
      pdv <= 1; fsr <= 1; repeat (8) @(posedge aclk);
      chk(bias, 1'b0); chk(fso, 1'b0);
      pdv <= 0; fsr <= 0; repeat (8) @(posedge aclk);
      chk(bias, 1'b1); chk(fso, 1'b1);
      @(posedge aclk iff dl === 1'b1); chk(pclk, 1'b1);
      lsr <= 1; @(posedge aclk iff lso === 1'b1); chk(pclk, 1'b1);
      lsr <= 0;
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_run;
      t_active;
      print_verdict;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      print_verdict;
   end
endmodule
`default_nettype wire
